// file: verilog/laser_error_status_logic.sv
// Error supervision: status byte, error output, substitute position
// Assumes synchronous measurement inputs and a synchronous parameter port
`timescale 1ns/10ps
`include "laser_status_defines.svh"

// Overview of operation
// - Error output follows seven-way selector
// - Substitute position when no measurement
// - Selector 0 gives zero position
// - Selector 1 gives all ones
// - Selector 2 holds last valid position
// - Parameter enables status in high byte
// - Bits clear when cause gone, or acknowledged
// - No fault gives zero status byte
// - Bit 0 below 8 percent or interrupted
// - Bit 1 temperature out of range
// - Low temperature only warns
// - Bit 2 hardware fault, substitutes position
// - Bit 3 emitter turned off
// - Bit 4 below 12 percent, still measuring
// - Bit 5 overspeed, check off by default
// - Bit 6 plausibility warning
// - Intensity percent read-only, at most 100
// - Manual ack by bit 3 or input
// - Position at most 24 bits
module laser_error_status_logic
(
    // Clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rst,
    // Parameter port from bus side
    input  wire laser_status_pkg::param_req_s i_param,
    output laser_status_pkg::byte_t          o_param_rdata,
    // Configuration
    input  wire logic                        i_auto_ack,
    input  wire logic                        i_speed_check_en,
    // Master output byte bits
    input  wire logic                        i_ack_bit,
    input  wire logic                        i_emitter_off_cmd,
    // Switching input pin and its configured role
    input  wire logic                        i_switch_pin,
    input  wire logic                        i_switch_is_ack,
    input  wire logic                        i_switch_is_emitter_off,
    // Measurement front end
    input  wire laser_status_pkg::position_t i_position,
    input  wire laser_status_pkg::byte_t     i_intensity_pct,
    input  wire logic                        i_beam_interrupted,
    input  wire logic                        i_temp_high,
    input  wire logic                        i_temp_low,
    input  wire logic                        i_hw_fault,
    input  wire logic                        i_overspeed,
    input  wire logic                        i_implausible,
    // Cyclic input data and pins
    output laser_status_pkg::input_data_s    o_input_data,
    output logic                             o_error_out,
    output logic                             o_emitter_off
);
    import laser_status_pkg::*;

    // Parameter, state and output registers
    byte_t       out_sel_ff;
    byte_t       subst_sel_ff;
    byte_t       bus_en_ff;
    byte_t       intensity_ff;
    byte_t       rdata_ff;
    position_t   last_valid_ff;
    input_data_s data_ff;
    logic        error_out_ff;
    logic        emitter_off_ff;
    logic        ack_bit_ff;

    // Switching input synchronised
    logic        switch_level;

    pin_sync3 u_switch_sync
    (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_switch_pin),
        .o_level (switch_level)
    );

    // Writes to decoded offsets; intensity offset not writable
    wire wr_out_sel   = i_param.wr && (i_param.addr == `OFS_ERR_OUT_SEL);
    wire wr_subst_sel = i_param.wr && (i_param.addr == `OFS_ERR_SUBST_SEL);
    wire wr_bus_en    = i_param.wr && (i_param.addr == `OFS_STATUS_BUS_EN);

    // Intensity clipped to 100
    wire   intens_over = i_intensity_pct > `INTENSITY_MAX_PCT;
    byte_t intens_clip;
    assign intens_clip = intens_over ? `INTENSITY_MAX_PCT : i_intensity_pct;

    // Read selection
    byte_t nxt_rdata;
    assign nxt_rdata =
        (i_param.addr == `OFS_ERR_OUT_SEL)   ? out_sel_ff   :
        (i_param.addr == `OFS_ERR_SUBST_SEL) ? subst_sel_ff :
        (i_param.addr == `OFS_STATUS_BUS_EN) ? bus_en_ff    :
        (i_param.addr == `OFS_INTENSITY_PCT) ? intensity_ff : 8'h00;

    // Causes of each status bit
    wire emitter_off_now = i_emitter_off_cmd | (i_switch_is_emitter_off & switch_level);
    wire intensity_low   = i_intensity_pct < `INTENSITY_ERR_PCT;
    wire intensity_warn  = i_intensity_pct < `INTENSITY_WARN_PCT;
    logic [`NUM_STATUS_BITS-1:0] cause;
    assign cause[`BIT_INTENSITY]    = intensity_low | i_beam_interrupted;
    assign cause[`BIT_TEMPERATURE]  = i_temp_high | i_temp_low;
    assign cause[`BIT_HARDWARE]     = i_hw_fault;
    assign cause[`BIT_EMITTER_OFF]  = emitter_off_now;
    assign cause[`BIT_INTENS_WARN]  = intensity_warn;
    assign cause[`BIT_OVERSPEED]    = i_speed_check_en & i_overspeed;
    assign cause[`BIT_PLAUSIBILITY] = i_implausible;

    // Acknowledge on rising edge of ack bit or while switching input is high
    wire ack_rise  = i_ack_bit & ~ack_bit_ff;
    wire ack_pulse = ack_rise | (i_switch_is_ack & switch_level);

    logic [`NUM_STATUS_BITS-1:0] flags;
    status_s                     status;

    genvar g;
    generate
        for (g = 0; g < `NUM_STATUS_BITS; g = g + 1)
        begin : g_bit
            status_bit_latch u_bit
            (
                .i_clock    (i_clock),
                .i_rst      (i_rst),
                .i_cause    (cause[g]),
                .i_auto_ack (i_auto_ack),
                .i_ack      (ack_pulse),
                .o_flag     (flags[g])
            );
        end
    endgenerate

    assign status = status_s'(flags);

    // No measurement only on intensity below 8 percent, beam loss or hardware fault; low temperature only warns
    wire no_measure = cause[`BIT_INTENSITY] | cause[`BIT_HARDWARE];

    // Substitute position
    position_t subst_pos;
    assign subst_pos =
        (subst_sel_ff == `SEL_SUBST_ONES) ? `POS_ONES      :
        (subst_sel_ff == `SEL_SUBST_LAST) ? last_valid_ff  :
        `POS_ZERO;

    position_t nxt_position;
    assign nxt_position = no_measure ? subst_pos : i_position;

    wire   bus_en = bus_en_ff != 8'h00;
    byte_t nxt_status_byte;
    assign nxt_status_byte = bus_en ? {1'b0, flags} : 8'h00;

    // Error output selection
    logic nxt_error_out;
    assign nxt_error_out =
        (out_sel_ff == `SEL_OUT_TEMP)   ? status.temperature  :
        (out_sel_ff == `SEL_OUT_INTENS) ? status.intensity    :
        (out_sel_ff == `SEL_OUT_HW)     ? status.hardware     :
        (out_sel_ff == `SEL_OUT_ANY)    ? (|flags)            :
        (out_sel_ff == `SEL_OUT_SPEED)  ? status.overspeed    :
        (out_sel_ff == `SEL_OUT_PLAUS)  ? status.plausibility :
        1'b0;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            out_sel_ff   <= `RST_ERR_OUT_SEL;
            subst_sel_ff <= `RST_ERR_SUBST_SEL;
            bus_en_ff    <= `RST_STATUS_BUS_EN;
            rdata_ff     <= 8'h00;
        end
        else
        begin
            if (wr_out_sel)
                out_sel_ff <= i_param.wdata;
            if (wr_subst_sel)
                subst_sel_ff <= i_param.wdata;
            if (wr_bus_en)
                bus_en_ff <= i_param.wdata;
            if (i_param.rd)
                rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            intensity_ff   <= 8'h00;
            last_valid_ff  <= `POS_ZERO;
            data_ff        <= '0;
            error_out_ff   <= 1'b0;
            emitter_off_ff <= 1'b0;
            ack_bit_ff     <= 1'b0;
        end
        else
        begin
            intensity_ff   <= intens_clip;
            if (!no_measure)
                last_valid_ff <= i_position;
            data_ff        <= {nxt_status_byte, nxt_position};
            error_out_ff   <= nxt_error_out;
            emitter_off_ff <= emitter_off_now;
            ack_bit_ff     <= i_ack_bit;
        end
    end

    assign o_param_rdata = rdata_ff;
    assign o_input_data  = data_ff;
    assign o_error_out   = error_out_ff;
    assign o_emitter_off = emitter_off_ff;

    // Error output selection
    a_error_out_sel: assert property (@(posedge i_clock) disable iff (i_rst)
        out_sel_ff == `SEL_OUT_ANY |=> o_error_out == $past(|flags))
        else $error("any-fault output does not follow status");

    a_error_out_off: assert property (@(posedge i_clock) disable iff (i_rst)
        $past(out_sel_ff) == `SEL_OUT_OFF |-> !o_error_out)
        else $error("disabled error output asserted");

    a_error_out_temp: assert property (@(posedge i_clock) disable iff (i_rst)
        out_sel_ff == `SEL_OUT_TEMP |=> o_error_out == $past(status.temperature))
        else $error("temperature error output wrong");

    a_error_out_intens: assert property (@(posedge i_clock) disable iff (i_rst)
        out_sel_ff == `SEL_OUT_INTENS |=> o_error_out == $past(status.intensity))
        else $error("intensity error output wrong");

    a_error_out_hw: assert property (@(posedge i_clock) disable iff (i_rst)
        out_sel_ff == `SEL_OUT_HW |=> o_error_out == $past(status.hardware))
        else $error("hardware error output wrong");

    a_error_out_speed: assert property (@(posedge i_clock) disable iff (i_rst)
        out_sel_ff == `SEL_OUT_SPEED |=> o_error_out == $past(status.overspeed))
        else $error("speed error output wrong");

    a_error_out_plaus: assert property (@(posedge i_clock) disable iff (i_rst)
        out_sel_ff == `SEL_OUT_PLAUS |=> o_error_out == $past(status.plausibility))
        else $error("plausibility error output wrong");

    // Substitute position
    a_subst_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        no_measure && subst_sel_ff == `SEL_SUBST_ZERO |=> o_input_data.position == `POS_ZERO)
        else $error("zero substitute not sent");

    a_subst_ones: assert property (@(posedge i_clock) disable iff (i_rst)
        no_measure && subst_sel_ff == `SEL_SUBST_ONES |=> o_input_data.position == `POS_ONES)
        else $error("all ones substitute not sent");

    a_subst_last: assert property (@(posedge i_clock) disable iff (i_rst)
        !no_measure ##1 (no_measure && subst_sel_ff == `SEL_SUBST_LAST)
        |=> o_input_data.position == $past(i_position, 2))
        else $error("last valid position not held");

    a_hw_subst: assert property (@(posedge i_clock) disable iff (i_rst)
        i_hw_fault && subst_sel_ff == `SEL_SUBST_ONES |=> o_input_data.position == `POS_ONES)
        else $error("hardware fault not substituted");

    a_measure_pass: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_beam_interrupted && !i_hw_fault && i_intensity_pct >= `INTENSITY_ERR_PCT
        |=> o_input_data.position == $past(i_position))
        else $error("good measurement not passed");

    a_temp_low_meas: assert property (@(posedge i_clock) disable iff (i_rst)
        i_temp_low && !i_hw_fault && !i_beam_interrupted && i_intensity_pct >= `INTENSITY_ERR_PCT
        |=> o_input_data.position == $past(i_position))
        else $error("low temperature disturbed measurement");

    // Status byte and flags
    a_status_gate: assert property (@(posedge i_clock) disable iff (i_rst)
        bus_en_ff == 8'h00 |=> o_input_data.status == 8'h00)
        else $error("status sent while disabled");

    a_status_on_bus: assert property (@(posedge i_clock) disable iff (i_rst)
        bus_en_ff != 8'h00 |=> o_input_data.status == {1'b0, $past(flags)})
        else $error("status not sent while enabled");

    a_status_idle: assert property (@(posedge i_clock) disable iff (i_rst)
        flags == 7'h00 |=> o_input_data.status == 8'h00)
        else $error("status byte not zero without fault");

    a_intens_bit: assert property (@(posedge i_clock) disable iff (i_rst)
        i_intensity_pct < `INTENSITY_ERR_PCT |=> flags[`BIT_INTENSITY] && flags[`BIT_INTENS_WARN])
        else $error("intensity flags not set");

    a_beam_bit: assert property (@(posedge i_clock) disable iff (i_rst)
        i_beam_interrupted |=> flags[`BIT_INTENSITY])
        else $error("beam loss flag not set");

    a_warn_bit: assert property (@(posedge i_clock) disable iff (i_rst)
        i_intensity_pct < `INTENSITY_WARN_PCT |=> flags[`BIT_INTENS_WARN])
        else $error("intensity warning not set");

    a_temp_bit: assert property (@(posedge i_clock) disable iff (i_rst)
        i_temp_high || i_temp_low |=> flags[`BIT_TEMPERATURE])
        else $error("temperature flag not set");

    a_hw_bit: assert property (@(posedge i_clock) disable iff (i_rst)
        i_hw_fault |=> flags[`BIT_HARDWARE])
        else $error("hardware flag not set");

    a_plaus_bit: assert property (@(posedge i_clock) disable iff (i_rst)
        i_implausible |=> flags[`BIT_PLAUSIBILITY])
        else $error("plausibility flag not set");

    a_speed_off: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_speed_check_en && i_auto_ack |=> !flags[`BIT_OVERSPEED])
        else $error("overspeed flag set while check off");

    // Acknowledge
    a_auto_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        i_auto_ack && !i_temp_high && !i_temp_low |=> !flags[`BIT_TEMPERATURE])
        else $error("flag not cleared automatically");

    a_manual_ack: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_auto_ack && ack_pulse && cause == 7'h00 |=> flags == 7'h00)
        else $error("acknowledge did not clear flags");

    // Emitter and intensity
    a_emitter_bit: assert property (@(posedge i_clock) disable iff (i_rst)
        i_emitter_off_cmd |=> flags[`BIT_EMITTER_OFF])
        else $error("emitter off flag not set");

    a_emitter_out: assert property (@(posedge i_clock) disable iff (i_rst)
        i_emitter_off_cmd |=> o_emitter_off)
        else $error("emitter off request not raised");

    a_emitter_clear: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_emitter_off_cmd && !switch_level |=> !o_emitter_off)
        else $error("emitter off request stuck");

    a_intensity_max: assert property (@(posedge i_clock) disable iff (i_rst)
        intensity_ff <= `INTENSITY_MAX_PCT)
        else $error("intensity above 100 percent");

    a_intens_track: assert property (@(posedge i_clock) disable iff (i_rst)
        i_intensity_pct <= `INTENSITY_MAX_PCT |=> intensity_ff == $past(i_intensity_pct))
        else $error("intensity register does not track input");

    a_read_intens: assert property (@(posedge i_clock) disable iff (i_rst)
        i_param.rd && i_param.addr == `OFS_INTENSITY_PCT |=> o_param_rdata == $past(intensity_ff))
        else $error("intensity read data wrong");
endmodule

// file: verilog/laser_status_defines.svh
// Offsets, reset values, field positions and thresholds of the error status logic
// Assumes inclusion by bare name from laser_error_status_logic and pin_sync3
`ifndef LASER_STATUS_DEFINES_SVH
`define LASER_STATUS_DEFINES_SVH

`define OFS_ERR_OUT_SEL      8'h0c
`define OFS_ERR_SUBST_SEL    8'h0d
`define OFS_STATUS_BUS_EN    8'h0e
`define OFS_INTENSITY_PCT    8'h0f

`define RST_ERR_OUT_SEL      8'h00
`define RST_ERR_SUBST_SEL    8'h00
`define RST_STATUS_BUS_EN    8'h00
`define RST_AUTO_ACK         1'b0

`define BIT_INTENSITY        0
`define BIT_TEMPERATURE      1
`define BIT_HARDWARE         2
`define BIT_EMITTER_OFF      3
`define BIT_INTENS_WARN      4
`define BIT_OVERSPEED        5
`define BIT_PLAUSIBILITY     6
`define NUM_STATUS_BITS      7

`define INTENSITY_ERR_PCT    8'h08
`define INTENSITY_WARN_PCT   8'h0c
`define INTENSITY_MAX_PCT    8'h64

`define SEL_OUT_OFF          8'h00
`define SEL_OUT_TEMP         8'h01
`define SEL_OUT_INTENS       8'h02
`define SEL_OUT_HW           8'h03
`define SEL_OUT_ANY          8'h04
`define SEL_OUT_SPEED        8'h05
`define SEL_OUT_PLAUS        8'h06

`define SEL_SUBST_ZERO       8'h00
`define SEL_SUBST_ONES       8'h01
`define SEL_SUBST_LAST       8'h02

`define POS_ZERO             24'h000000
`define POS_ONES             24'hffffff
`define SYNC_ZERO            3'h0

`endif

// file: verilog/laser_status_pkg.sv
// Types shared by the laser error status logic
// Assumes nothing beyond the defines header
package laser_status_pkg;
    typedef logic [23:0] position_t;
    typedef logic [7:0]  byte_t;

    typedef struct packed {
        logic plausibility;
        logic overspeed;
        logic intens_warn;
        logic emitter_off;
        logic hardware;
        logic temperature;
        logic intensity;
    } status_s;

    typedef struct packed {
        byte_t     status;
        position_t position;
    } input_data_s;

    typedef struct packed {
        logic  wr;
        logic  rd;
        byte_t addr;
        byte_t wdata;
    } param_req_s;
endpackage

// file: verilog/pin_sync3.sv
// Three flop synchroniser for an outside level
// Assumes i_clock domain; stage one is read only by stage two
`timescale 1ns/10ps
`include "laser_status_defines.svh"
module pin_sync3
(
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // Pin
    input  wire logic i_pin,
    output logic      o_level
);
    logic [2:0] sync_ff;
    logic       level_ff;
    wire        agree = sync_ff[1] == sync_ff[2];

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync_ff  <= `SYNC_ZERO;
            level_ff <= 1'b0;
        end
        else
        begin
            sync_ff  <= {sync_ff[1:0], i_pin};
            if (agree)
                level_ff <= sync_ff[2];
        end
    end

    assign o_level = level_ff;
endmodule

// file: verilog/status_bit_latch.sv
// One sticky status bit with cause, acknowledge and auto clear
// Assumes cause and acknowledge already synchronous
`timescale 1ns/10ps
module status_bit_latch
(
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // Control
    input  wire logic i_cause,
    input  wire logic i_auto_ack,
    input  wire logic i_ack,
    // Result
    output logic      o_flag
);
    logic flag_ff;
    logic nxt_flag;

    // Cause always wins over clear
    assign nxt_flag = i_cause | (flag_ff & ~i_auto_ack & ~i_ack);

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            flag_ff <= 1'b0;
        else
            flag_ff <= nxt_flag;
    end

    assign o_flag = flag_ff;

    a_flag_holds: assert property (@(posedge i_clock) disable iff (i_rst)
        $past(flag_ff) && !$past(i_auto_ack) && !$past(i_ack) |-> flag_ff)
        else $error("latched flag dropped without acknowledge");
endmodule

// file: bench/fieldbus_master_model.sv
// Fieldbus master model: parameter access and acknowledge bit
// Assumes the block clock; drives just after rising edges
`timescale 1ns/10ps
module fieldbus_master_model
(
    // Clock
    input  wire logic                        i_clock,
    // Parameter answer
    input  wire laser_status_pkg::byte_t     i_rdata,
    // Requests
    output laser_status_pkg::param_req_s     o_param,
    output logic                             o_ack_bit
);
    import laser_status_pkg::*;
    initial
    begin
        o_param   = '0;
        o_ack_bit = 1'b0;
    end
    // Single cycle write, then address and data no longer hold
    task automatic write_param(input byte_t a, input byte_t d);
        @(posedge i_clock);
        #1 o_param = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clock);
        #1 o_param = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic read_param(input byte_t a, output byte_t d);
        @(posedge i_clock);
        #1 o_param = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clock);
        #1 o_param = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        @(posedge i_clock);
        #1 d = i_rdata;
    endtask
    // Acknowledge by a rising edge of output byte bit 3
    task automatic ack_pulse();
        @(posedge i_clock);
        #1 o_ack_bit = 1'b1;
        repeat (2) @(posedge i_clock);
        #1 o_ack_bit = 1'b0;
    endtask
endmodule

// file: bench/laser_error_status_logic_bench.sv
// Self-checking bench of the error status logic
// Assumes the fieldbus master model for parameter access
`timescale 1ns/10ps
module laser_error_status_logic_bench;
    import laser_status_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic auto_ack = 1'b1, speed_en = 1'b0, emitter_cmd = 1'b0;
    logic switch_pin = 1'b0, sw_ack = 1'b0, sw_eoff = 1'b0;
    logic beam = 1'b0, temp_high = 1'b0, temp_low = 1'b0;
    logic hw_fault = 1'b0, overspeed = 1'b0, implausible = 1'b0;
    position_t   position = 24'h123456;
    byte_t       intensity = 8'h32;
    byte_t       rdata;
    byte_t       rd_val;
    param_req_s  param;
    logic        ack_bit, error_out, emitter_off;
    input_data_s input_data;
    int n_errors = 0;
    int cmp_count = 0;

    always #5 clock = ~clock;

    fieldbus_master_model master_inst (.i_clock(clock), .i_rdata(rdata),
        .o_param(param), .o_ack_bit(ack_bit));
    laser_error_status_logic laser_error_status_logic_inst (.i_clock(clock), .i_rst(rst),
        .i_param(param), .o_param_rdata(rdata), .i_auto_ack(auto_ack),
        .i_speed_check_en(speed_en), .i_ack_bit(ack_bit), .i_emitter_off_cmd(emitter_cmd),
        .i_switch_pin(switch_pin), .i_switch_is_ack(sw_ack), .i_switch_is_emitter_off(sw_eoff),
        .i_position(position), .i_intensity_pct(intensity), .i_beam_interrupted(beam),
        .i_temp_high(temp_high), .i_temp_low(temp_low), .i_hw_fault(hw_fault),
        .i_overspeed(overspeed), .i_implausible(implausible), .o_input_data(input_data),
        .o_error_out(error_out), .o_emitter_off(emitter_off));

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Drives one cause by index
    task automatic cause(input int k, input logic on);
        case (k)
            0: intensity = on ? 8'h05 : 8'h32;
            1: beam = on;
            2: temp_high = on;
            3: temp_low = on;
            4: hw_fault = on;
            5: emitter_cmd = on;
            6: intensity = on ? 8'h0a : 8'h32;
            7, 9: overspeed = on;
            default: implausible = on;
        endcase
        speed_en = (k == 7);
    endtask

    task automatic t_regs();
        for (int a = 12; a < 15; a++)
        begin
            master_inst.read_param(8'(a), rd_val);
            check("reset value", 32'(rd_val), 32'h0);
        end
        intensity = 8'h96;
        master_inst.write_param(8'h0f, 8'h00);
        master_inst.read_param(8'h0f, rd_val);
        check("intensity", 32'(rd_val), 32'h64);
        master_inst.write_param(8'h20, 8'h55);
        master_inst.read_param(8'h20, rd_val);
        check("unmapped", 32'(rd_val), 32'h0);
        master_inst.write_param(8'h0d, 8'h02);
        master_inst.read_param(8'h0d, rd_val);
        check("subst sel", 32'(rd_val), 32'h2);
        intensity = 8'h32;
        $display("t_regs done");
    endtask

    task automatic t_status();
        byte_t exp[10] = '{8'h11, 8'h01, 8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h00};
        master_inst.write_param(8'h0e, 8'h01);
        for (int k = 0; k < 10; k++)
        begin
            cause(k, 1'b1);
            tick(3);
            check("status set", 32'(input_data.status), 32'(exp[k]));
            cause(k, 1'b0);
            tick(3);
            check("status idle", 32'(input_data.status), 32'h0);
        end
        master_inst.write_param(8'h0e, 8'h00);
        temp_high = 1'b1;
        tick(3);
        check("status off", 32'(input_data.status), 32'h0);
        temp_high = 1'b0;
        tick(3);
        $display("t_status done");
    endtask

    task automatic t_errout();
        int ck[5] = '{2, 0, 4, 7, 8};
        for (int s = 0; s < 7; s++)
        begin
            master_inst.write_param(8'h0c, 8'(s));
            for (int j = 0; j < 5; j++)
            begin
                cause(ck[j], 1'b1);
                tick(3);
                check("error out", 32'(error_out), 32'(s == 4 || s == j + (j > 2) + 1));
                cause(ck[j], 1'b0);
                tick(3);
                check("error out idle", 32'(error_out), 32'h0);
            end
        end
        master_inst.write_param(8'h0c, 8'h00);
        $display("t_errout done");
    endtask

    task automatic t_subst();
        position_t exp[3] = '{24'h000000, 24'hffffff, 24'h123456};
        for (int s = 0; s < 3; s++)
        begin
            master_inst.write_param(8'h0d, 8'(s));
            tick(3);
            beam = 1'b1;
            position = 24'h654321;
            tick(3);
            check("subst pos", 32'(input_data.position), 32'(exp[s]));
            beam = 1'b0;
            position = 24'h123456;
        end
        master_inst.write_param(8'h0d, 8'h01);
        hw_fault = 1'b1;
        tick(3);
        check("hw subst", 32'(input_data.position), 32'hffffff);
        hw_fault = 1'b0;
        temp_low = 1'b1;
        intensity = 8'h0a;
        position = 24'h654321;
        tick(3);
        check("warn pos", 32'(input_data.position), 32'h654321);
        temp_low = 1'b0;
        intensity = 8'h32;
        tick(3);
        $display("t_subst done");
    endtask

    task automatic t_ack();
        auto_ack = 1'b0;
        master_inst.write_param(8'h0e, 8'h01);
        temp_high = 1'b1;
        tick(3);
        temp_high = 1'b0;
        tick(5);
        check("latched", 32'(input_data.status), 32'h02);
        master_inst.ack_pulse();
        tick(3);
        check("bus ack", 32'(input_data.status), 32'h0);
        temp_high = 1'b1;
        master_inst.ack_pulse();
        tick(3);
        check("cause wins", 32'(input_data.status), 32'h02);
        temp_high = 1'b0;
        sw_ack = 1'b1;
        tick(3);
        check("no ack yet", 32'(input_data.status), 32'h02);
        switch_pin = 1'b1;
        tick(8);
        check("pin ack", 32'(input_data.status), 32'h0);
        switch_pin = 1'b0;
        sw_ack = 1'b0;
        auto_ack = 1'b1;
        sw_eoff = 1'b1;
        switch_pin = 1'b1;
        tick(8);
        check("pin emitter", 32'(emitter_off), 32'h1);
        check("emitter bit", 32'(input_data.status), 32'h08);
        switch_pin = 1'b0;
        tick(8);
        check("emitter on", 32'(emitter_off), 32'h0);
        $display("t_ack done");
    endtask

    initial
    begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial
    begin
        tick(5);
        rst = 1'b0;
        tick(2);
        t_regs();
        t_status();
        t_errout();
        t_subst();
        t_ack();
        finish_test();
    end
endmodule
